// ---- logic/nnc_config_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "nnc_cfg.svh"
module nnc_config_regs #(
    parameter int ADDR_W = 8,
    parameter int unsigned RESP_CYC_FULL = `NNC_RESP_FULL_NS * `NNC_CLK_MHZ / 1000,
    parameter int unsigned RESP_CYC_HALF = `NNC_RESP_HALF_NS * `NNC_CLK_MHZ / 1000,
    parameter int unsigned RESP_CYC_QTR = `NNC_RESP_QTR_NS * `NNC_CLK_MHZ / 1000,
    parameter int unsigned RESP_CYC_SHORT = `NNC_RESP_SHORT_NS * `NNC_CLK_MHZ / 1000,
    parameter int unsigned IDLE_CYC_FULL = `NNC_IDLE_FULL_NS * `NNC_CLK_MHZ / 1000,
    parameter int unsigned IDLE_CYC_HALF = `NNC_IDLE_HALF_NS * `NNC_CLK_MHZ / 1000,
    parameter int unsigned IDLE_CYC_QTR = `NNC_IDLE_QTR_NS * `NNC_CLK_MHZ / 1000,
    parameter int unsigned IDLE_CYC_SHORT = `NNC_IDLE_SHORT_NS * `NNC_CLK_MHZ / 1000,
    parameter int unsigned RECON_CYC_LONG = `NNC_RECON_LONG_MS * `NNC_CLK_KHZ,
    parameter int unsigned RECON_CYC_SHORT = `NNC_RECON_SHORT_MS * `NNC_CLK_KHZ
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // avalon-mm slave
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // protocol engine requests
    input wire logic eng_tx_active,
    input wire logic eng_pulse_a,
    input wire logic eng_pulse_b,
    input wire logic eng_nak_fbe,
    input wire logic eng_clear_excess,
    // controls to the engine
    output logic soft_reset_active,
    output logic chain_commands_on,
    output logic backplane_mode,
    output logic [2:0] indirect_reg_select,
    output logic [31:0] resp_cycles,
    output logic [31:0] idle_cycles,
    output logic [31:0] recon_cycles,
    output logic excess_nak_flag,
    // media interface
    output logic line_driver_enable_n,
    output logic line_pulse_a_n,
    output logic line_pulse_a_oe,
    output logic line_pulse_b_n,
    // interrupt
    output logic irq
);
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
        return a == ADDR_W'(ofs);
    endfunction

    nnc_pkg::nnc_byte_t network_configuration;
    nnc_pkg::nnc_byte_t line_setup_one;
    logic indirect_reg_select_top;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    nnc_pkg::nnc_byte_t rd_byte;
    nnc_pkg::nnc_byte_t wd;
    nnc_pkg::nnc_tmo_e tmo_sel;
    logic wr_done;
    logic tx_ok;
    logic bplane;
    logic pulse_gate;
    logic pulse_a_drive;
    logic [1:0] irq_events;
    logic [1:0] irq_clear;

    nnc_nak_if nak_bus ();

    assign wd = avs_writedata[7:0];
    // writes take effect only at the edge where waitrequest is seen low
    assign wr_done = avs_write && !avs_waitrequest && avs_byteenable[0];
    assign tx_ok = network_configuration[`NNC_CFG_TRANSMITTER_ALLOW];
    assign bplane = network_configuration[`NNC_CFG_BPLANE];
    assign tmo_sel = nnc_pkg::nnc_tmo_e'({network_configuration[`NNC_CFG_TMO_HI],
                                          network_configuration[`NNC_CFG_TMO_LO]});

    // one wait cycle per access, then a single low cycle
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            avs_waitrequest <= 1'b1;
        end else if ((avs_read || avs_write) && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    always_comb begin
        rd_byte = 8'h00;
        if (hit(avs_address, `NNC_OFS_CONFIG)) begin
            rd_byte = network_configuration;
        end else if (hit(avs_address, `NNC_OFS_SETUP1)) begin
            rd_byte = line_setup_one;
        end else if (hit(avs_address, `NNC_OFS_SUBAD)) begin
            rd_byte = {5'h00, indirect_reg_select_top, network_configuration[1:0]};
        end else if (hit(avs_address, `NNC_OFS_DIAG)) begin
            rd_byte = {7'h00, excess_nak_flag};
        end else if (hit(avs_address, `NNC_OFS_IRQ_STATUS)) begin
            rd_byte = {6'h00, irq_status};
        end else if (hit(avs_address, `NNC_OFS_IRQ_MASK)) begin
            rd_byte = {6'h00, irq_mask};
        end
    end

    // unmapped addresses read zero
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && avs_waitrequest) begin
            avs_readdata <= {24'h00_0000, rd_byte};
        end
    end

    // soft reset never touches this register
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            network_configuration <= `NNC_CONFIG_RST;
        end else if (wr_done && hit(avs_address, `NNC_OFS_CONFIG)) begin
            network_configuration <= wd;
        end else if (wr_done && hit(avs_address, `NNC_OFS_SUBAD)) begin
            network_configuration[1:0] <= wd[1:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            indirect_reg_select_top <= 1'b0;
        end else if (wr_done && hit(avs_address, `NNC_OFS_CONFIG)) begin
            indirect_reg_select_top <= 1'b0;
        end else if (wr_done && hit(avs_address, `NNC_OFS_SUBAD)) begin
            indirect_reg_select_top <= wd[2];
        end
    end

    // reserved bit is not stored, so a stray one cannot leak out
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            line_setup_one <= `NNC_SETUP1_RST;
        end else if (wr_done && hit(avs_address, `NNC_OFS_SETUP1)) begin
            line_setup_one <= wd & `NNC_SU1_WMASK;
        end
    end

    // control outputs
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            soft_reset_active <= 1'b0;
            chain_commands_on <= 1'b0;
            backplane_mode <= 1'b0;
            indirect_reg_select <= 3'h0;
        end else begin
            // stays until the host writes the bit back to zero
            soft_reset_active <= network_configuration[`NNC_CFG_SRST];
            chain_commands_on <= network_configuration[`NNC_CFG_CHAIN];
            backplane_mode <= bplane;
            indirect_reg_select <= {indirect_reg_select_top,
                                    network_configuration[1:0]};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            resp_cycles <= 32'(RESP_CYC_FULL);
            idle_cycles <= 32'(IDLE_CYC_FULL);
            recon_cycles <= 32'(RECON_CYC_LONG);
        end else begin
            unique case (tmo_sel)
                nnc_pkg::nnc_tmo_full: begin
                    resp_cycles <= 32'(RESP_CYC_FULL);
                    idle_cycles <= 32'(IDLE_CYC_FULL);
                    recon_cycles <= 32'(RECON_CYC_LONG);
                end
                nnc_pkg::nnc_tmo_half: begin
                    resp_cycles <= 32'(RESP_CYC_HALF);
                    idle_cycles <= 32'(IDLE_CYC_HALF);
                    recon_cycles <= 32'(RECON_CYC_LONG);
                end
                nnc_pkg::nnc_tmo_quarter: begin
                    resp_cycles <= 32'(RESP_CYC_QTR);
                    idle_cycles <= 32'(IDLE_CYC_QTR);
                    recon_cycles <= 32'(RECON_CYC_LONG);
                end
                nnc_pkg::nnc_tmo_short: begin
                    resp_cycles <= 32'(RESP_CYC_SHORT);
                    idle_cycles <= 32'(IDLE_CYC_SHORT);
                    recon_cycles <= 32'(RECON_CYC_SHORT);
                end
            endcase
        end
    end

    // backplane pulses are not gated by transmit enable; a node held
    // in soft reset is kept off the line as well
    assign pulse_gate = (tx_ok || bplane) && !network_configuration[`NNC_CFG_SRST];
    assign pulse_a_drive = eng_pulse_a && pulse_gate;

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            line_driver_enable_n <= 1'b1;
            line_pulse_a_n <= 1'b1;
            line_pulse_a_oe <= 1'b1;
            line_pulse_b_n <= 1'b1;
        end else begin
            line_driver_enable_n <= !(tx_ok && eng_tx_active
                                      && !network_configuration[`NNC_CFG_SRST]);
            line_pulse_b_n <= !(eng_pulse_b && pulse_gate);
            if (bplane && !line_setup_one[`NNC_SU1_PA_TYPE]) begin
                // open drain: only ever pull low
                line_pulse_a_n <= 1'b0;
                line_pulse_a_oe <= pulse_a_drive;
            end else begin
                line_pulse_a_n <= !pulse_a_drive;
                line_pulse_a_oe <= 1'b1;
            end
        end
    end

    assign nak_bus.nak_event = eng_nak_fbe;
    assign nak_bus.short_sel = line_setup_one[`NNC_SU1_SHORT_NAK];
    // diagnostics are wiped for as long as soft reset is held
    assign nak_bus.clear = eng_clear_excess || network_configuration[`NNC_CFG_SRST];

    nnc_nak_counter u_nak (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .nak(nak_bus)
    );

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            excess_nak_flag <= 1'b0;
        end else begin
            excess_nak_flag <= nak_bus.flag;
        end
    end

    assign irq_events[`NNC_IRQ_EXNAK] = nak_bus.flag && !excess_nak_flag;
    assign irq_events[`NNC_IRQ_SRST] = network_configuration[`NNC_CFG_SRST]
                                       && !soft_reset_active;
    assign irq_clear = (wr_done && hit(avs_address, `NNC_OFS_IRQ_STATUS)) ? wd[1:0] : 2'h0;

    // set wins over a write-one clear in the same cycle
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            irq_status <= `NNC_IRQ_RST;
        end else begin
            irq_status <= (irq_status & ~irq_clear) | irq_events;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            irq_mask <= `NNC_IRQ_RST;
        end else if (wr_done && hit(avs_address, `NNC_OFS_IRQ_MASK)) begin
            irq_mask <= wd[1:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_mask);
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    chk_transmitter_allow_after_reset: assert property ($rose(rstn) |-> !tx_ok ##1 line_driver_enable_n)
        else $error("transmit enable not clear after reset");
    chk_driver_quiet: assert property (!tx_ok |=> line_driver_enable_n)
        else $error("line driver enabled with transmit disabled");
    chk_pulse_quiet: assert property (!tx_ok && !bplane |=> line_pulse_a_n && line_pulse_b_n)
        else $error("pulse driven with transmit disabled");
    chk_srst_follow: assert property (
        network_configuration[`NNC_CFG_SRST] |-> nak_bus.clear ##1 soft_reset_active)
        else $error("soft reset not held");
    chk_srst_keep_cfg: assert property (
        soft_reset_active && !wr_done |=> $stable(network_configuration))
        else $error("soft reset altered configuration");
    chk_subad_clear: assert property (
        wr_done && hit(avs_address, `NNC_OFS_CONFIG) |=> ##1 indirect_reg_select[2] == 1'b0)
        else $error("top sub-address bit survived config write");
    chk_pa_open_drain: assert property (
        bplane && !line_setup_one[`NNC_SU1_PA_TYPE] |=> !line_pulse_a_n)
        else $error("open drain pulse output drove high");
    chk_short_recon: assert property (
        tmo_sel == nnc_pkg::nnc_tmo_short |=> recon_cycles == 32'(RECON_CYC_SHORT))
        else $error("short reconfig time not selected");
    chk_chain_follow: assert property (
        $changed(network_configuration[`NNC_CFG_CHAIN]) |=>
        chain_commands_on == $past(network_configuration[`NNC_CFG_CHAIN]))
        else $error("chaining enable not followed");
    chk_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("access not answered in one wait cycle");
    chk_reserved_zero: assert property (line_setup_one[5] == 1'b0)
        else $error("reserved setup bit stored");

    cov_soft_reset: cover property ($rose(soft_reset_active) ##[1:20] $fell(soft_reset_active));
    cov_excess_irq: cover property ($rose(excess_nak_flag) ##[1:4] irq);
    cov_backplane_pulse: cover property (backplane_mode && line_pulse_a_oe && !line_pulse_a_n);
    cov_tx_line: cover property (!line_driver_enable_n);
endmodule
`default_nettype wire

// ---- logic/nnc_cfg.svh ----
`ifndef NNC_CFG_SVH
`define NNC_CFG_SVH

// register byte offsets, one 32-bit word each
`define NNC_OFS_CONFIG 8'h00
`define NNC_OFS_SETUP1 8'h04
`define NNC_OFS_SUBAD 8'h08
`define NNC_OFS_DIAG 8'h0C
`define NNC_OFS_IRQ_STATUS 8'h10
`define NNC_OFS_IRQ_MASK 8'h14

// network_configuration fields
`define NNC_CFG_SRST 7
`define NNC_CFG_CHAIN 6
`define NNC_CFG_TRANSMITTER_ALLOW 5
`define NNC_CFG_TMO_LO 4
`define NNC_CFG_TMO_HI 3
`define NNC_CFG_BPLANE 2

// line_setup_one fields
`define NNC_SU1_PA_TYPE 7
`define NNC_SU1_SHORT_NAK 6
`define NNC_SU1_WMASK 8'hDF

// irq status bits
`define NNC_IRQ_EXNAK 0
`define NNC_IRQ_SRST 1

// reset values
`define NNC_CONFIG_RST 8'h00
`define NNC_SETUP1_RST 8'h00
`define NNC_IRQ_RST 2'h0

// excess nak thresholds
`define NNC_NAK_SHORT 8'h04
`define NNC_NAK_LONG 8'h80

// core clock and timeouts
`define NNC_CLK_MHZ 200
`define NNC_CLK_KHZ 200000
`define NNC_RESP_FULL_NS 596600
`define NNC_RESP_HALF_NS 298400
`define NNC_RESP_QTR_NS 149200
`define NNC_RESP_SHORT_NS 37400
`define NNC_IDLE_FULL_NS 656000
`define NNC_IDLE_HALF_NS 328000
`define NNC_IDLE_QTR_NS 164000
`define NNC_IDLE_SHORT_NS 41000
`define NNC_RECON_LONG_MS 840
`define NNC_RECON_SHORT_MS 420

`endif

// ---- logic/nnc_pkg.sv ----
package nnc_pkg;
    // ordered as the two-bit selector {hi, lo}
    typedef enum logic [1:0] {
        nnc_tmo_full,
        nnc_tmo_half,
        nnc_tmo_quarter,
        nnc_tmo_short
    } nnc_tmo_e;
    typedef logic [7:0] nnc_byte_t;
endpackage

// ---- logic/nnc_nak_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface nnc_nak_if;
    logic nak_event;
    logic short_sel;
    logic clear;
    logic flag;
    modport cnt (input nak_event, input short_sel, input clear, output flag);
    modport ctl (output nak_event, output short_sel, output clear, input flag);
endinterface
`default_nettype wire

// ---- logic/nnc_nak_counter.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "nnc_cfg.svh"
module nnc_nak_counter (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // counter side of the nak carrier
    nnc_nak_if.cnt nak
);
    function automatic nnc_pkg::nnc_byte_t nak_thr(input logic short_sel);
        return short_sel ? `NNC_NAK_SHORT : `NNC_NAK_LONG;
    endfunction

    nnc_pkg::nnc_byte_t count;
    nnc_pkg::nnc_byte_t base;
    nnc_pkg::nnc_byte_t base_inc;
    logic hit;

    // a clear in the same cycle as a nak restarts counting at that nak
    assign base = nak.clear ? 8'h00 : count;
    assign base_inc = (base >= nak_thr(nak.short_sel)) ? base : base + 8'h01;
    assign hit = nak.nak_event && (base_inc >= nak_thr(nak.short_sel));

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            count <= 8'h00;
        end else if (nak.nak_event) begin
            count <= base_inc;
        end else begin
            count <= base;
        end
    end

    // set wins over clear
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            nak.flag <= 1'b0;
        end else if (hit) begin
            nak.flag <= 1'b1;
        end else if (nak.clear) begin
            nak.flag <= 1'b0;
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    chk_flag_on_hit: assert property (hit |=> nak.flag)
        else $error("excess nak flag not set at threshold");
    chk_flag_early: assert property (
        nak.clear && !nak.nak_event ##1 (!nak.nak_event && !nak.clear) [*3] |=> !nak.flag)
        else $error("excess nak flag set before threshold");
    chk_short_four: assert property (
        nak.short_sel && nak.clear && nak.nak_event ##1
        (nak.short_sel && nak.nak_event && !nak.clear) [*3] |=> nak.flag)
        else $error("four naks did not set flag in short mode");
endmodule
`default_nettype wire

// ---- bench/nnc_eng_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module nnc_eng_model (
    // clock
    input wire logic ref_clk,
    // engine requests toward the register block
    output logic eng_tx_active,
    output logic eng_pulse_a,
    output logic eng_pulse_b,
    output logic eng_nak_fbe,
    output logic eng_clear_excess
);
    initial begin
        eng_tx_active = 1'b0;
        eng_pulse_a = 1'b0;
        eng_pulse_b = 1'b0;
        eng_nak_fbe = 1'b0;
        eng_clear_excess = 1'b0;
    end
    task automatic drive_line(input logic tx, input logic pa, input logic pb);
        @(posedge ref_clk);
        eng_tx_active <= tx;
        eng_pulse_a <= pa;
        eng_pulse_b <= pb;
    endtask
    // one-cycle pulse per nak; gap 0 gives the densest train the engine makes
    task automatic send_naks(input int n, input int gap);
        for (int i = 0; i < n; i++) begin
            @(posedge ref_clk);
            eng_nak_fbe <= 1'b1;
            @(posedge ref_clk);
            eng_nak_fbe <= 1'b0;
            repeat (gap) @(posedge ref_clk);
        end
    endtask
    task automatic clear_flags();
        @(posedge ref_clk);
        eng_clear_excess <= 1'b1;
        @(posedge ref_clk);
        eng_clear_excess <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- bench/node_network_config_regs_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "nnc_cfg.svh"
module node_network_config_regs_tb;
    logic ref_clk;
    logic rstn;
    logic [7:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [3:0] avs_byteenable;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic eng_tx_active, eng_pulse_a, eng_pulse_b, eng_nak_fbe, eng_clear_excess;
    logic soft_reset_active, chain_commands_on, backplane_mode, excess_nak_flag;
    logic [2:0] indirect_reg_select;
    logic [31:0] resp_cycles, idle_cycles, recon_cycles;
    logic line_driver_enable_n, line_pulse_a_n, line_pulse_a_oe, line_pulse_b_n, irq;
    int err_total = 0;
    int checked = 0;
    int cyc = 0;
    // expected cycle counts follow from the nominal times and the core clock rate
    int resp_tab[4] = '{`NNC_RESP_FULL_NS * `NNC_CLK_MHZ / 1000,
                        `NNC_RESP_HALF_NS * `NNC_CLK_MHZ / 1000,
                        `NNC_RESP_QTR_NS * `NNC_CLK_MHZ / 1000,
                        `NNC_RESP_SHORT_NS * `NNC_CLK_MHZ / 1000};
    int idle_tab[4] = '{`NNC_IDLE_FULL_NS * `NNC_CLK_MHZ / 1000,
                        `NNC_IDLE_HALF_NS * `NNC_CLK_MHZ / 1000,
                        `NNC_IDLE_QTR_NS * `NNC_CLK_MHZ / 1000,
                        `NNC_IDLE_SHORT_NS * `NNC_CLK_MHZ / 1000};
    int recon_tab[4] = '{`NNC_RECON_LONG_MS * `NNC_CLK_KHZ, `NNC_RECON_LONG_MS * `NNC_CLK_KHZ,
                         `NNC_RECON_LONG_MS * `NNC_CLK_KHZ, `NNC_RECON_SHORT_MS * `NNC_CLK_KHZ};
    logic [7:0] rnd;
    logic [7:0] m_cfg, m_su1;
    logic m_top;
    logic [31:0] q;

    nnc_config_regs i_dut (
        .ref_clk(ref_clk), .rstn(rstn),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .eng_tx_active(eng_tx_active), .eng_pulse_a(eng_pulse_a),
        .eng_pulse_b(eng_pulse_b), .eng_nak_fbe(eng_nak_fbe),
        .eng_clear_excess(eng_clear_excess),
        .soft_reset_active(soft_reset_active), .chain_commands_on(chain_commands_on),
        .backplane_mode(backplane_mode), .indirect_reg_select(indirect_reg_select),
        .resp_cycles(resp_cycles), .idle_cycles(idle_cycles), .recon_cycles(recon_cycles),
        .excess_nak_flag(excess_nak_flag),
        .line_driver_enable_n(line_driver_enable_n), .line_pulse_a_n(line_pulse_a_n),
        .line_pulse_a_oe(line_pulse_a_oe), .line_pulse_b_n(line_pulse_b_n), .irq(irq)
    );

    nnc_eng_model i_eng (
        .ref_clk(ref_clk), .eng_tx_active(eng_tx_active), .eng_pulse_a(eng_pulse_a),
        .eng_pulse_b(eng_pulse_b), .eng_nak_fbe(eng_nak_fbe),
        .eng_clear_excess(eng_clear_excess)
    );

    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic tally_and_finish();
        if (err_total == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] adr, input logic [7:0] d,
                       input logic [3:0] be);
        @(posedge ref_clk);
        avs_address <= adr;
        avs_writedata <= {24'h0, d};
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] adr, input logic [7:0] exp);
        bus(1'b0, adr, 8'h00, 4'hf);
        check(q, {24'h0, exp});
    endtask
    task automatic wcfg(input logic [7:0] d);
        bus(1'b1, `NNC_OFS_CONFIG, d, 4'hf);
        m_cfg = d;
        m_top = 1'b0;
    endtask
    task automatic wsu1(input logic [7:0] d);
        // reserved bit 5 always written as zero
        m_su1 = d & 8'hdf;
        bus(1'b1, `NNC_OFS_SETUP1, m_su1, 4'hf);
    endtask
    task automatic settle();
        repeat (3) @(posedge ref_clk);
        #1;
    endtask
    task automatic check_outs();
        logic [1:0] sel;
        sel = {m_cfg[3], m_cfg[4]};
        check(soft_reset_active, m_cfg[7]);
        check(chain_commands_on, m_cfg[6]);
        check(backplane_mode, m_cfg[2]);
        check(indirect_reg_select, {m_top, m_cfg[1:0]});
        check(resp_cycles, resp_tab[sel]);
        check(idle_cycles, idle_tab[sel]);
        check(recon_cycles, recon_tab[sel]);
    endtask
    task automatic check_line(input logic en_n, input logic a_n, input logic oe,
                              input logic b_n);
        check({line_driver_enable_n, line_pulse_a_n, line_pulse_a_oe, line_pulse_b_n},
              {en_n, a_n, oe, b_n});
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            tally_and_finish();
        end
    end

    initial begin
        rstn = 1'b0;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
        rnd = 8'h1e;
        m_cfg = 8'h00;
        m_su1 = 8'h00;
        m_top = 1'b0;
        repeat (16) @(posedge ref_clk);
        rstn <= 1'b1;
        #1;
        rd_chk(`NNC_OFS_CONFIG, 8'h00);
        rd_chk(`NNC_OFS_SETUP1, 8'h00);
        check_line(1'b1, 1'b1, 1'b1, 1'b1);
        check_outs();
        // every timeout selection, random other fields with soft reset bit 7 held at zero, top sub-address bit set first
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr_next(rnd);
            bus(1'b1, `NNC_OFS_SUBAD, {5'h00, 1'b1, rnd[1:0]}, 4'hf);
            m_cfg[1:0] = rnd[1:0];
            m_top = 1'b1;
            rd_chk(`NNC_OFS_SUBAD, {5'h00, m_top, m_cfg[1:0]});
            wcfg({1'b0, rnd[6:5], i[0], i[1], rnd[4:2]});
            rd_chk(`NNC_OFS_SUBAD, {5'h00, 1'b0, m_cfg[1:0]});
            rd_chk(`NNC_OFS_CONFIG, m_cfg);
            settle();
            check_outs();
            rnd = lfsr_next(rnd);
            wsu1(rnd);
            rd_chk(`NNC_OFS_SETUP1, m_su1);
        end
        bus(1'b1, `NNC_OFS_CONFIG, 8'hff, 4'he);
        rd_chk(`NNC_OFS_CONFIG, m_cfg);
        rd_chk(8'h3c, 8'h00);
        // line gating by transmitter_allow and backplane
        wsu1(8'h00);
        wcfg(8'h00);
        i_eng.drive_line(1'b1, 1'b1, 1'b1);
        settle();
        check_line(1'b1, 1'b1, 1'b1, 1'b1);
        wcfg(8'h20);
        settle();
        check_line(1'b0, 1'b0, 1'b1, 1'b0);
        wcfg(8'h04);
        settle();
        check_line(1'b1, 1'b0, 1'b1, 1'b0);
        i_eng.drive_line(1'b1, 1'b0, 1'b1);
        settle();
        check_line(1'b1, 1'b0, 1'b0, 1'b0);
        wsu1(8'h80);
        settle();
        check_line(1'b1, 1'b1, 1'b1, 1'b0);
        // short nak threshold with interrupt raise, mask and clear
        bus(1'b1, `NNC_OFS_IRQ_MASK, 8'h03, 4'hf);
        wsu1(8'h40);
        i_eng.send_naks(3, 0);
        settle();
        check(excess_nak_flag, 1'b0);
        i_eng.send_naks(1, 3);
        settle();
        check(excess_nak_flag, 1'b1);
        rd_chk(`NNC_OFS_DIAG, 8'h01);
        rd_chk(`NNC_OFS_IRQ_STATUS, 8'h01);
        check(irq, 1'b1);
        bus(1'b1, `NNC_OFS_IRQ_MASK, 8'h00, 4'hf);
        settle();
        check(irq, 1'b0);
        bus(1'b1, `NNC_OFS_IRQ_MASK, 8'h03, 4'hf);
        bus(1'b1, `NNC_OFS_IRQ_STATUS, 8'h01, 4'hf);
        settle();
        rd_chk(`NNC_OFS_IRQ_STATUS, 8'h00);
        check(irq, 1'b0);
        i_eng.clear_flags();
        settle();
        check(excess_nak_flag, 1'b0);
        // long threshold counted to the boundary
        wsu1(8'h00);
        i_eng.send_naks(127, 0);
        settle();
        check(excess_nak_flag, 1'b0);
        i_eng.send_naks(1, 0);
        settle();
        check(excess_nak_flag, 1'b1);
        bus(1'b1, `NNC_OFS_IRQ_STATUS, 8'h03, 4'hf);
        // soft reset clears diagnostics only and holds until bit 7 is cleared
        wsu1(8'h40);
        i_eng.drive_line(1'b1, 1'b1, 1'b1);
        wcfg(8'ha4);
        settle();
        check(excess_nak_flag, 1'b0);
        check_line(1'b1, 1'b0, 1'b0, 1'b1);
        check_outs();
        rd_chk(`NNC_OFS_CONFIG, 8'ha4);
        rd_chk(`NNC_OFS_SETUP1, 8'h40);
        rd_chk(`NNC_OFS_IRQ_STATUS, 8'h02);
        check(irq, 1'b1);
        wcfg(8'h24);
        settle();
        check_outs();
        check_line(1'b0, 1'b0, 1'b1, 1'b0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
